// ### nas_alu_checker.sv
`timescale 1ns/10ps
`default_nettype none

// Watches handshake, carry and accumulator results of the datapath
module nas_alu_checker
  import nas_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Operation port
  input wire logic op_valid,
  input wire logic [4:0] op_code,
  input wire logic op_ready,
  input wire logic op_done,
  input wire logic op_skipped,
  // State and memory strobes
  input wire logic carry_flag,
  input wire logic skip_pending,
  input wire logic [63:0] reg_file,
  input wire logic mem_rd,
  input wire logic mem_we
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  logic run; // Taken and really executed
  assign run = op_valid && op_ready && !skip_pending;

  AST_CY_SET: assert property (run && op_code == NAS_OP_CY_SET
    |-> ##2 carry_flag) else $error("carry not set");
  AST_CY_CLR: assert property (run && op_code == NAS_OP_CY_CLR
    |-> ##2 !carry_flag) else $error("carry not cleared");
  AST_CY_NOT: assert property (run && op_code == NAS_OP_CY_NOT
    |-> ##2 carry_flag != $past(carry_flag, 2)) else $error("no invert");
  AST_SKT: assert property (run && op_code == NAS_OP_SKT_CY
    |-> ##2 skip_pending == $past(carry_flag, 2)) else $error("carry test");
  AST_NOTA: assert property (run && op_code == NAS_OP_NOTA
    |-> ##2 reg_file[7:4] == ~$past(reg_file[7:4], 2))
    else $error("complement wrong");
  AST_ROTATE_THROUGH_CARRY: assert property (run && op_code == NAS_OP_ROTATE_THROUGH_CARRY
    |-> ##2 {reg_file[7:4], carry_flag} ==
    {$past(carry_flag, 2), $past(reg_file[7:4], 2)}) else $error("rotate");
  AST_SUBTRACT_SKIP_ON_BORROW_CY: assert property (run && op_code == NAS_OP_SUBTRACT_SKIP_ON_BORROW_WIDE
    |-> ##2 carry_flag == $past(carry_flag, 2)) else $error("carry moved");
  AST_NULLIFY: assert property (op_valid && op_ready && skip_pending
    |=> op_done && op_skipped && $stable(reg_file) && $stable(carry_flag)
    && !mem_we) else $error("skipped op changed state");
  // A chained add passed over after a borrow-free subtract keeps ready high
  AST_BUSY: assert property (run |=> !op_ready || op_skipped)
    else $error("ready high");
  AST_RD_PULSE: assert property (mem_rd |=> !mem_rd) else $error("read");

  // Main scenarios
  cover property (op_skipped);
  cover property (run && op_code == NAS_OP_SUBTRACT_WITH_BORROW_FLAG_NIB);
  cover property (mem_we);
endmodule : nas_alu_checker

bind nas_alu_core nas_alu_checker i_chk (.core_clk, .arst_n, .op_valid,
  .op_code, .op_ready, .op_done, .op_skipped, .carry_flag, .skip_pending,
  .reg_file, .mem_rd, .mem_we);

`default_nettype wire

// ### nas_alu_core.sv
`timescale 1ns/10ps
`default_nettype none

// How it works
// - Wide skip subtract: write difference, skip on borrow
// - Nibble borrow subtract: A minus memory minus carry
// - Following immediate add: skip or run unskippable
// - Wide borrow subtract either direction, carry from borrow
// - AND accumulator with immediate or memory nibble
// - Wide AND in either direction
// - OR on nibble and wide forms
// - XOR on nibble and wide forms
// - Rotate accumulator right through carry
// - Complement all accumulator bits
// - Register increment skips on zero
// - Pair increment skips on 00
// - Memory increment skips on zero
// - Register decrement skips on F
// - Pair decrement skips on FF
// - Compare register or memory with immediate
// - Compare accumulator or wide pair, skip equal
// - Pair memory compare, even-aligned address
// - Carry set, clear and invert
// - Carry test skips when carry set
// - Direct memory bit set and clear
// - Fixed, peripheral and page bit forms
module nas_alu_core
  import nas_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Decoded operation
  input wire logic op_valid,
  input wire logic [4:0] op_code,
  input wire logic [1:0] op_fn,
  input wire logic op_dir,
  input wire logic [2:0] op_pair,
  input wire logic [3:0] op_reg,
  input wire logic [7:0] op_imm,
  input wire logic [1:0] op_bit,
  input wire logic [2:0] op_amode,
  output logic op_ready,
  output logic op_done,
  output logic op_skipped,
  // Architectural state
  output logic carry_flag,
  output logic skip_pending,
  output logic [63:0] reg_file,
  // Data memory port
  input wire logic [3:0] mem_bank,
  input wire logic [3:0] mem_rdata,
  output logic [11:0] mem_addr,
  output logic mem_rd,
  output logic mem_we,
  output logic [3:0] mem_wdata
);

  // Sequencer states
  typedef enum logic [1:0] {
    NAS_S_IDLE,
    NAS_S_MREQ,
    NAS_S_MCAP,
    NAS_S_EXEC
  } nas_state_t;

  // Whole state of the block
  typedef struct packed {
    nas_state_t st;
    nas_op_t op;
    nas_fn_t fn;
    logic dir;
    logic [2:0] psel;
    logic [3:0] rsel;
    logic [7:0] imm;
    logic nosk;
    logic second;
    logic [3:0] md0;
    logic [3:0] md1;
    logic [15:0][3:0] rf;
    logic cy;
    logic skip;
    logic chain;
    logic chain_nob;
    logic rdy;
    logic done;
    logic skipped;
    logic [11:0] maddr;
    logic [1:0] mbit;
    logic mrd;
    logic mwe;
    logic [3:0] mwd;
  } nas_st_t;

  nas_st_t s_q; // Registered state
  nas_st_t s_d; // Next state
  logic [11:0] form_addr; // Address formed from the incoming operands
  logic [1:0] form_bit; // Bit index formed from the incoming operands
  logic [2:0] am_eff; // Addressing form after the pair compare override

  // Outputs straight from the state flops
  assign op_ready = s_q.rdy;
  assign op_done = s_q.done;
  assign op_skipped = s_q.skipped;
  assign carry_flag = s_q.cy;
  assign skip_pending = s_q.skip;
  assign reg_file = s_q.rf;
  assign mem_addr = s_q.maddr;
  assign mem_rd = s_q.mrd;
  assign mem_we = s_q.mwe;
  assign mem_wdata = s_q.mwd;

  // The pair compare always reads an even-aligned address
  assign am_eff = (op_code == NAS_OP_SKE_XA_MEM) ? NAS_AM_HL_EVEN
                  : op_amode;

  // Address former works on the operands offered at accept time
  nas_mem_addr u_addr (
    .amode(am_eff),
    .imm(op_imm),
    .bsel(op_bit),
    .mbank(mem_bank),
    .h_nib(s_q.rf[4'h2]),
    .l_nib(s_q.rf[4'h3]),
    .addr(form_addr),
    .bit_idx(form_bit)
  );

  // Logic unit shared by nibble and wide forms
  function automatic logic [7:0] nas_logic(input nas_fn_t fn,
                                           input logic [7:0] a,
                                           input logic [7:0] b);
    unique case (fn)
      NAS_FN_AND: nas_logic = a & b;
      NAS_FN_OR: nas_logic = a | b;
      NAS_FN_XOR: nas_logic = a ^ b;
      default: nas_logic = a & b;
    endcase
  endfunction : nas_logic

  // Operations that fetch a memory nibble before executing
  function automatic logic nas_needs_mem(input logic [4:0] code);
    nas_needs_mem = (code == NAS_OP_SUBTRACT_WITH_BORROW_FLAG_NIB) || (code == NAS_OP_LOGIC_MEM)
      || (code == NAS_OP_INCREMENT_SKIP_ON_ZERO_MEM) || (code == NAS_OP_SKE_MEM_IMM)
      || (code == NAS_OP_SKE_A_MEM) || (code == NAS_OP_SKE_XA_MEM)
      || (code == NAS_OP_BIT_SET) || (code == NAS_OP_BIT_CLR);
  endfunction : nas_needs_mem

  // Next-state logic
  always_comb begin
    logic [7:0] xa;
    logic [7:0] pr;
    logic [7:0] a8;
    logic [7:0] b8;
    logic [7:0] r8;
    logic [8:0] d9;
    logic [4:0] d5;
    logic [3:0] n4;
    logic [2:0] dp;
    logic sk;
    logic wr8;
    xa = {s_q.rf[NAS_IDX_X], s_q.rf[NAS_IDX_A]};
    pr = {s_q.rf[{s_q.psel, 1'b0}], s_q.rf[{s_q.psel, 1'b1}]};
    // Direction bit set means the named pair is the destination
    a8 = s_q.dir ? pr : xa;
    b8 = s_q.dir ? xa : pr;
    dp = s_q.dir ? s_q.psel : NAS_PAIR_XA;
    r8 = 8'h00;
    d9 = 9'h000;
    d5 = 5'h00;
    n4 = 4'h0;
    sk = 1'b0;
    wr8 = 1'b0;
    s_d = s_q;
    // Strobes default low so each lasts one cycle
    s_d.done = 1'b0;
    s_d.skipped = 1'b0;
    s_d.mrd = 1'b0;
    s_d.mwe = 1'b0;
    unique case (s_q.st)
      NAS_S_IDLE: begin
        if (op_valid && s_q.rdy) begin
          s_d.op = nas_op_t'(op_code);
          s_d.fn = nas_fn_t'(op_fn);
          s_d.dir = op_dir;
          s_d.psel = op_pair;
          s_d.rsel = op_reg;
          s_d.imm = op_imm;
          s_d.second = 1'b0;
          s_d.nosk = 1'b0;
          s_d.chain = 1'b0;
          // A pending skip swallows this op whole
          if (s_q.skip) begin
            s_d.skip = 1'b0;
            s_d.done = 1'b1;
            s_d.skipped = 1'b1;
          end else if (s_q.chain && (op_code == NAS_OP_ADDS_IMM)
                       && s_q.chain_nob) begin
            // No borrow before: the adjusting add is passed over
            s_d.done = 1'b1;
            s_d.skipped = 1'b1;
          end else begin
            // After a borrow the add runs but cannot skip
            s_d.nosk = s_q.chain && (op_code == NAS_OP_ADDS_IMM);
            s_d.rdy = 1'b0;
            s_d.maddr = form_addr;
            s_d.mbit = form_bit;
            if (nas_needs_mem(op_code)) begin
              s_d.mrd = 1'b1;
              s_d.st = NAS_S_MREQ;
            end else begin
              s_d.st = NAS_S_EXEC;
            end
          end
        end
      end
      // Read request is on the port this cycle
      NAS_S_MREQ: s_d.st = NAS_S_MCAP;
      // Read data is valid this cycle
      NAS_S_MCAP: begin
        if (s_q.second) begin
          s_d.md1 = mem_rdata;
          s_d.st = NAS_S_EXEC;
        end else begin
          s_d.md0 = mem_rdata;
          if (s_q.op == NAS_OP_SKE_XA_MEM) begin
            // High nibble sits at the next address
            s_d.second = 1'b1;
            s_d.maddr = s_q.maddr | 12'h001;
            s_d.mrd = 1'b1;
            s_d.st = NAS_S_MREQ;
          end else begin
            s_d.st = NAS_S_EXEC;
          end
        end
      end
      NAS_S_EXEC: begin
        s_d.st = NAS_S_IDLE;
        s_d.rdy = 1'b1;
        s_d.done = 1'b1;
        unique case (s_q.op)
          NAS_OP_ADDS_IMM: begin
            d5 = {1'b0, s_q.rf[NAS_IDX_A]} + {1'b0, s_q.imm[3:0]};
            s_d.rf[NAS_IDX_A] = d5[3:0];
            sk = d5[4] & ~s_q.nosk;
          end
          NAS_OP_SUBTRACT_SKIP_ON_BORROW_WIDE: begin
            // Carry untouched, borrow only steers the skip
            d9 = {1'b0, a8} - {1'b0, b8};
            r8 = d9[7:0];
            wr8 = 1'b1;
            sk = d9[8];
          end
          NAS_OP_SUBTRACT_WITH_BORROW_FLAG_NIB: begin
            d5 = {1'b0, s_q.rf[NAS_IDX_A]} - {1'b0, s_q.md0}
                 - {4'h0, s_q.cy};
            s_d.rf[NAS_IDX_A] = d5[3:0];
            s_d.cy = d5[4];
            // Arm the decimal-adjust pairing for the next op
            s_d.chain = 1'b1;
            s_d.chain_nob = ~d5[4];
          end
          NAS_OP_SUBTRACT_WITH_BORROW_FLAG_WIDE: begin
            d9 = {1'b0, a8} - {1'b0, b8} - {8'h00, s_q.cy};
            r8 = d9[7:0];
            wr8 = 1'b1;
            s_d.cy = d9[8];
          end
          NAS_OP_LOGIC_IMM, NAS_OP_LOGIC_MEM: begin
            n4 = (s_q.op == NAS_OP_LOGIC_IMM) ? s_q.imm[3:0] : s_q.md0;
            r8 = nas_logic(s_q.fn, {4'h0, s_q.rf[NAS_IDX_A]}, {4'h0, n4});
            s_d.rf[NAS_IDX_A] = r8[3:0];
          end
          NAS_OP_LOGIC_WIDE: begin
            r8 = nas_logic(s_q.fn, a8, b8);
            wr8 = 1'b1;
          end
          NAS_OP_ROTATE_THROUGH_CARRY: begin
            s_d.cy = s_q.rf[NAS_IDX_A][0];
            s_d.rf[NAS_IDX_A] = {s_q.cy, s_q.rf[NAS_IDX_A][3:1]};
          end
          NAS_OP_NOTA: s_d.rf[NAS_IDX_A] = ~s_q.rf[NAS_IDX_A];
          NAS_OP_INCREMENT_SKIP_ON_ZERO_REG: begin
            n4 = s_q.rf[s_q.rsel] + 4'h1;
            s_d.rf[s_q.rsel] = n4;
            sk = (n4 == 4'h0);
          end
          NAS_OP_INCREMENT_SKIP_ON_ZERO_PAIR: begin
            r8 = pr + 8'h01;
            dp = s_q.psel;
            wr8 = 1'b1;
            sk = (r8 == 8'h00);
          end
          NAS_OP_INCREMENT_SKIP_ON_ZERO_MEM: begin
            n4 = s_q.md0 + 4'h1;
            s_d.mwd = n4;
            s_d.mwe = 1'b1;
            sk = (n4 == 4'h0);
          end
          NAS_OP_DECREMENT_SKIP_ON_WRAP_REG: begin
            n4 = s_q.rf[s_q.rsel] - 4'h1;
            s_d.rf[s_q.rsel] = n4;
            sk = (n4 == 4'hF);
          end
          NAS_OP_DECREMENT_SKIP_ON_WRAP_PAIR: begin
            r8 = pr - 8'h01;
            dp = s_q.psel;
            wr8 = 1'b1;
            sk = (r8 == 8'hFF);
          end
          NAS_OP_SKE_REG_IMM: sk = (s_q.rf[s_q.rsel] == s_q.imm[3:0]);
          NAS_OP_SKE_MEM_IMM: sk = (s_q.md0 == s_q.imm[3:0]);
          NAS_OP_SKE_A_MEM: sk = (s_q.rf[NAS_IDX_A] == s_q.md0);
          NAS_OP_SKE_A_REG: sk = (s_q.rf[NAS_IDX_A] == s_q.rf[s_q.rsel]);
          NAS_OP_SKE_XA_PAIR: sk = (xa == pr);
          NAS_OP_SKE_XA_MEM: sk = (xa == {s_q.md1, s_q.md0});
          NAS_OP_CY_SET: s_d.cy = 1'b1;
          NAS_OP_CY_CLR: s_d.cy = 1'b0;
          NAS_OP_CY_NOT: s_d.cy = ~s_q.cy;
          NAS_OP_SKT_CY: sk = s_q.cy;
          NAS_OP_BIT_SET, NAS_OP_BIT_CLR: begin
            // Read-modify-write of one bit of the fetched nibble
            s_d.mwd = s_q.md0;
            s_d.mwd[s_q.mbit] = (s_q.op == NAS_OP_BIT_SET);
            s_d.mwe = 1'b1;
          end
          default: sk = 1'b0;
        endcase
        // Wide results land in the high and low nibble of the pair
        if (wr8) begin
          s_d.rf[{dp, 1'b0}] = r8[7:4];
          s_d.rf[{dp, 1'b1}] = r8[3:0];
        end
        s_d.skip = sk;
      end
      default: s_d.st = NAS_S_IDLE;
    endcase
  end

  // State register; every field has a constant reset value
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
      s_q.st <= NAS_S_IDLE;
      s_q.rf <= {16{NAS_RST_NIB}};
      s_q.cy <= NAS_RST_CARRY;
      s_q.rdy <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : nas_alu_core
`default_nettype wire

// ### nas_mem_addr.sv
`timescale 1ns/10ps
`default_nettype none

// Forms a data memory nibble address and bit index from an addressing form
module nas_mem_addr
  import nas_pkg::*;
(
  // Addressing form and operands
  input wire logic [2:0] amode,
  input wire logic [7:0] imm,
  input wire logic [1:0] bsel,
  input wire logic [3:0] mbank,
  // Current pointer pair nibbles
  input wire logic [3:0] h_nib,
  input wire logic [3:0] l_nib,
  // Formed address
  output logic [11:0] addr,
  output logic [1:0] bit_idx
);

  // Pure decode; the caller registers the result
  always_comb begin
    addr = {mbank, h_nib, l_nib};
    bit_idx = bsel;
    unique case (nas_amode_t'(amode))
      NAS_AM_HL: addr = {mbank, h_nib, l_nib};
      // Odd low pointer drops its lsb for the pair compare
      NAS_AM_HL_EVEN: addr = {mbank, h_nib, l_nib[3:1], 1'b0};
      NAS_AM_DIRECT: addr = {mbank, imm};
      // Fixed area: bit 4 picks the upper block
      NAS_AM_FIXED: begin
        addr = (imm[4] ? NAS_FIXED_HI_BASE : NAS_FIXED_LO_BASE)
               | {8'h00, imm[3:0]};
      end
      // Peripheral bit: imm and L[3:2] give the word, L[1:0] the bit
      NAS_AM_PERIPH: begin
        addr = NAS_PERIPH_BASE | {6'h00, imm[3:0], l_nib[3:2]};
        bit_idx = l_nib[1:0];
      end
      // Page pointer plus address bit
      NAS_AM_HBASE: addr = {mbank, h_nib, imm[3:0]};
      default: addr = {mbank, h_nib, l_nib};
    endcase
  end

endmodule : nas_mem_addr
`default_nettype wire

// ### nas_mem_model.sv
`timescale 1ns/10ps
`default_nettype none

// Data memory on the far side; read data is valid one cycle after mem_rd
module nas_mem_model (
  // Clock
  input wire logic core_clk,
  // Access port
  input wire logic [11:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_we,
  input wire logic [3:0] mem_wdata,
  output logic [3:0] mem_rdata
);
  logic [3:0] mem [0:4095]; // Nibble store
  // Start from a cleared store
  initial begin
    foreach (mem[i]) mem[i] = 4'h0;
  end
  // Stale read data toggles, so a sample one cycle late never matches by chance
  always @(posedge core_clk) begin
    if (mem_rd) mem_rdata <= mem[mem_addr];
    else mem_rdata <= ~mem_rdata;
    if (mem_we) mem[mem_addr] <= mem_wdata;
  end
endmodule : nas_mem_model

`default_nettype wire

// ### nas_pkg.sv
package nas_pkg;

  // Operations the decoder hands to the datapath
  typedef enum logic [4:0] {
    NAS_OP_NOP,
    NAS_OP_ADDS_IMM,
    NAS_OP_SUBTRACT_SKIP_ON_BORROW_WIDE,
    NAS_OP_SUBTRACT_WITH_BORROW_FLAG_NIB,
    NAS_OP_SUBTRACT_WITH_BORROW_FLAG_WIDE,
    NAS_OP_LOGIC_IMM,
    NAS_OP_LOGIC_MEM,
    NAS_OP_LOGIC_WIDE,
    NAS_OP_ROTATE_THROUGH_CARRY,
    NAS_OP_NOTA,
    NAS_OP_INCREMENT_SKIP_ON_ZERO_REG,
    NAS_OP_INCREMENT_SKIP_ON_ZERO_PAIR,
    NAS_OP_INCREMENT_SKIP_ON_ZERO_MEM,
    NAS_OP_DECREMENT_SKIP_ON_WRAP_REG,
    NAS_OP_DECREMENT_SKIP_ON_WRAP_PAIR,
    NAS_OP_SKE_REG_IMM,
    NAS_OP_SKE_MEM_IMM,
    NAS_OP_SKE_A_MEM,
    NAS_OP_SKE_XA_MEM,
    NAS_OP_SKE_A_REG,
    NAS_OP_SKE_XA_PAIR,
    NAS_OP_CY_SET,
    NAS_OP_CY_CLR,
    NAS_OP_CY_NOT,
    NAS_OP_SKT_CY,
    NAS_OP_BIT_SET,
    NAS_OP_BIT_CLR
  } nas_op_t;

  // Logic function for the conjunction family
  typedef enum logic [1:0] {
    NAS_FN_AND,
    NAS_FN_OR,
    NAS_FN_XOR
  } nas_fn_t;

  // Data memory addressing forms
  typedef enum logic [2:0] {
    NAS_AM_HL,
    NAS_AM_HL_EVEN,
    NAS_AM_DIRECT,
    NAS_AM_FIXED,
    NAS_AM_PERIPH,
    NAS_AM_HBASE
  } nas_amode_t;

  // Register file positions: bank is index bit 3
  localparam logic [3:0] NAS_IDX_X = 4'h0;
  localparam logic [3:0] NAS_IDX_A = 4'h1;
  localparam logic [2:0] NAS_PAIR_XA = 3'h0;

  // Fixed bit area and peripheral bit area bases
  localparam logic [11:0] NAS_FIXED_LO_BASE = 12'hFB0;
  localparam logic [11:0] NAS_FIXED_HI_BASE = 12'hFF0;
  localparam logic [11:0] NAS_PERIPH_BASE = 12'hFC0;

  // Values after reset
  localparam logic [3:0] NAS_RST_NIB = 4'h0;
  localparam logic NAS_RST_CARRY = 1'b0;

endpackage : nas_pkg

// ### testbench.sv
`timescale 1ns/10ps
`default_nettype none

// Hand-made scenarios against the nibble datapath
module testbench
  import nas_pkg::*;
;
  // Stimulus
  logic core_clk, arst_n, op_valid, op_dir;
  logic [4:0] op_code;
  logic [1:0] op_fn, op_bit;
  logic [2:0] op_pair, op_amode;
  logic [3:0] op_reg, mem_bank, mem_rdata, mem_wdata;
  logic [7:0] op_imm;
  // Observed
  logic op_ready, op_done, op_skipped, carry_flag, skip_pending;
  logic mem_rd, mem_we;
  logic [11:0] mem_addr;
  logic [63:0] reg_file;
  int n_mismatch, cmp_count, cycles; // Counters
  // Device and its memory
  nas_alu_core i_dut (.core_clk, .arst_n, .op_valid, .op_code, .op_fn,
    .op_dir, .op_pair, .op_reg, .op_imm, .op_bit, .op_amode, .op_ready,
    .op_done, .op_skipped, .carry_flag, .skip_pending, .reg_file,
    .mem_bank, .mem_rdata, .mem_addr, .mem_rd, .mem_we, .mem_wdata);
  nas_mem_model i_mem (.core_clk, .mem_addr, .mem_rd, .mem_we,
    .mem_wdata, .mem_rdata);
  // 40 MHz clock
  always #12.5 core_clk = ~core_clk;
  // Hang guard; the whole run needs well under this
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  // Register nibble by index
  function automatic logic [3:0] nib(input int i);
    return reg_file[4*i +: 4];
  endfunction : nib
  // Verdict and end of run
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop
  // Value compare
  task automatic chk(input string what, input logic [63:0] e,
                     input logic [63:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", what, e, g);
    end
  endtask : chk
  // Offer one op at a falling edge, wait for its done pulse
  task automatic issue(input nas_op_t c, input logic [7:0] im);
    int n;
    n = 0;
    op_code = c;
    op_imm = im;
    op_valid = 1'h1;
    @(negedge core_clk);
    op_valid = 1'h0;
    while (op_done !== 1'h1 && n < 10) begin
      @(negedge core_clk);
      n++;
    end
    if (n == 10) chk("op_done", 64'h1, 64'h0);
  endtask : issue
  // An invert that must be nullified
  task automatic eat_skip();
    logic c;
    c = carry_flag;
    issue(NAS_OP_CY_NOT, 8'h00);
    chk("skipped", 64'h1, op_skipped);
    chk("carry kept", c, carry_flag);
  endtask : eat_skip
  // Carry set, invert and test
  task automatic t_carry();
    chk("reset", 64'h1, {reg_file, carry_flag, op_ready});
    issue(NAS_OP_CY_SET, 8'h00);
    chk("cy set", 64'h1, carry_flag);
    issue(NAS_OP_SKT_CY, 8'h00);
    chk("skt", 64'h1, skip_pending);
    eat_skip();
    issue(NAS_OP_CY_NOT, 8'h00);
    chk("cy not", 64'h0, carry_flag);
    issue(NAS_OP_SKT_CY, 8'h00);
    chk("skt", 64'h0, skip_pending);
  endtask : t_carry
  // Logic functions on immediate, memory and wide forms
  task automatic t_logic();
    nas_fn_t f [3] = '{NAS_FN_OR, NAS_FN_XOR, NAS_FN_AND};
    logic [3:0] v [3] = '{4'h5, 4'hF, 4'h6};
    logic [3:0] e [3] = '{4'h5, 4'hA, 4'h2};
    for (int i = 0; i < 3; i++) begin
      op_fn = f[i];
      issue(NAS_OP_LOGIC_IMM, {4'h0, v[i]});
      chk("A imm", e[i], nib(1));
    end
    i_mem.mem[0] = 4'hC;
    op_fn = NAS_FN_OR;
    issue(NAS_OP_LOGIC_MEM, 8'h00);
    chk("A mem", 64'hE, nib(1));
    op_fn = NAS_FN_XOR;
    op_dir = 1'h1;
    op_pair = 3'h2;
    issue(NAS_OP_LOGIC_WIDE, 8'h00);
    chk("pair xor", 64'h0E, {nib(4), nib(5)});
  endtask : t_logic
  // Rotate through carry, then complement
  task automatic t_rotate();
    issue(NAS_OP_CY_SET, 8'h00);
    issue(NAS_OP_ROTATE_THROUGH_CARRY, 8'h00);
    chk("rotate_through_carry", 64'h1E, {nib(1), carry_flag});
    issue(NAS_OP_NOTA, 8'h00);
    chk("not", 64'h0, nib(1));
  endtask : t_rotate
  // Wrap and non-wrap steps on a register, wrap steps only on a pair
  task automatic t_incdec();
    op_reg = 4'h0;
    issue(NAS_OP_DECREMENT_SKIP_ON_WRAP_REG, 8'h00);
    chk("dec reg", 64'h1F, {nib(0), skip_pending});
    eat_skip();
    issue(NAS_OP_INCREMENT_SKIP_ON_ZERO_REG, 8'h00);
    chk("inc reg", 64'h01, {nib(0), skip_pending});
    eat_skip();
    issue(NAS_OP_INCREMENT_SKIP_ON_ZERO_REG, 8'h00);
    chk("inc reg", 64'h02, {nib(0), skip_pending});
    issue(NAS_OP_DECREMENT_SKIP_ON_WRAP_REG, 8'h00);
    chk("dec reg", 64'h00, {nib(0), skip_pending});
    op_pair = 3'h1;
    issue(NAS_OP_DECREMENT_SKIP_ON_WRAP_PAIR, 8'h00);
    chk("dec pair", 64'h1FF, {nib(2), nib(3), skip_pending});
    eat_skip();
    issue(NAS_OP_INCREMENT_SKIP_ON_ZERO_PAIR, 8'h00);
    chk("inc pair", 64'h001, {nib(2), nib(3), skip_pending});
    eat_skip();
  endtask : t_incdec
  // Memory increment, compares and bit writes
  task automatic t_mem();
    i_mem.mem[0] = 4'hF;
    op_amode = NAS_AM_HL;
    issue(NAS_OP_INCREMENT_SKIP_ON_ZERO_MEM, 8'h00);
    // The write strobe stands with done; the store takes it one edge later
    @(negedge core_clk);
    chk("inc mem", 64'h01, {i_mem.mem[0], skip_pending});
    eat_skip();
    issue(NAS_OP_SKE_MEM_IMM, 8'h01);
    chk("ske imm", 64'h0, skip_pending);
    issue(NAS_OP_SKE_A_MEM, 8'h00);
    chk("ske a", 64'h1, skip_pending);
    eat_skip();
    mem_bank = 4'h3;
    op_amode = NAS_AM_DIRECT;
    op_bit = 2'h2;
    issue(NAS_OP_BIT_SET, 8'h12);
    @(negedge core_clk);
    chk("bit set", 64'h4, i_mem.mem[12'h312]);
    i_mem.mem[12'h312] = 4'hF;
    issue(NAS_OP_BIT_CLR, 8'h12);
    @(negedge core_clk);
    chk("bit clr", 64'hB, i_mem.mem[12'h312]);
  endtask : t_mem
  // Register and pair compares, pair memory compare, peripheral bit
  task automatic t_cmp();
    // Here X=0, A=2, pointer pair=FF, pair 2=0E, carry set
    op_reg = 4'h5;
    issue(NAS_OP_SKE_REG_IMM, 8'h0E);
    chk("ske reg imm", 64'h1, skip_pending);
    eat_skip();
    op_reg = 4'h4;
    issue(NAS_OP_SKE_A_REG, 8'h00);
    chk("ske a reg", 64'h0, skip_pending);
    op_pair = 3'h2;
    issue(NAS_OP_SKE_XA_PAIR, 8'h00);
    chk("ske xa pair", 64'h0, skip_pending);
    // Odd pointer FF must read FE then FF
    mem_bank = 4'h0;
    i_mem.mem[12'h0FE] = 4'h2;
    i_mem.mem[12'h0FF] = 4'h0;
    issue(NAS_OP_SKE_XA_MEM, 8'h00);
    chk("ske xa mem", 64'h1, skip_pending);
    eat_skip();
    // Peripheral form: word from imm and L[3:2], bit from L[1:0]
    op_amode = NAS_AM_PERIPH;
    i_mem.mem[12'hFCF] = 4'h0;
    issue(NAS_OP_BIT_SET, 8'h03);
    @(negedge core_clk);
    chk("bit periph", 64'h8, i_mem.mem[12'hFCF]);
  endtask : t_cmp
  // Borrow subtracts and the paired immediate add
  task automatic t_sub();
    mem_bank = 4'h0;
    op_amode = NAS_AM_HL;
    i_mem.mem[0] = 4'h7;
    issue(NAS_OP_SUBTRACT_WITH_BORROW_FLAG_NIB, 8'h00);
    chk("subtract_with_borrow_flag", 64'h13, {nib(1), carry_flag});
    issue(NAS_OP_ADDS_IMM, 8'h08);
    chk("adds run", 64'h06, {nib(1), carry_flag, skip_pending});
    issue(NAS_OP_CY_CLR, 8'h00);
    chk("cy clr", 64'h0, carry_flag);
    i_mem.mem[0] = 4'h1;
    issue(NAS_OP_SUBTRACT_WITH_BORROW_FLAG_NIB, 8'h00);
    issue(NAS_OP_ADDS_IMM, 8'h05);
    chk("adds skip", 64'h01, {nib(1), op_skipped});
    op_reg = 4'h1;
    issue(NAS_OP_INCREMENT_SKIP_ON_ZERO_REG, 8'h00);
    op_dir = 1'h1;
    issue(NAS_OP_SUBTRACT_SKIP_ON_BORROW_WIDE, 8'h00);
    chk("subtract_skip_on_borrow", 64'h3FD, {nib(2), nib(3), carry_flag, skip_pending});
    eat_skip();
    op_dir = 1'h0;
    issue(NAS_OP_SUBTRACT_WITH_BORROW_FLAG_WIDE, 8'h00);
    chk("subtract_with_borrow_flag wide", 64'h005, {nib(0), nib(1), carry_flag});
  endtask : t_sub
  // Main sequence
  initial begin
    core_clk = 1'h0;
    arst_n = 1'h0;
    op_valid = 1'h0;
    op_code = 5'h00;
    op_fn = 2'h0;
    op_dir = 1'h0;
    op_pair = 3'h0;
    op_reg = 4'h0;
    op_imm = 8'h00;
    op_bit = 2'h0;
    op_amode = 3'h0;
    mem_bank = 4'h0;
    repeat (3) @(negedge core_clk);
    arst_n = 1'h1;
    t_carry();
    t_logic();
    t_rotate();
    t_incdec();
    t_mem();
    t_sub();
    t_cmp();
    report_and_stop();
  end
endmodule : testbench

`default_nettype wire
